// file: hw/rsr_ctrl.sv
// Reset and stop mode recovery controller
// Summary of operation
// - Power-on, brown-out and a low reset pin each start a system reset.
// - A watchdog time-out resets the chip only if the reset select is set.
// - Bit 0 of the debug control register set to 1 starts a system reset.
// - In stop mode, watchdog, enabled GPIO edge or low debug pin recover.
// - Reset type follows from the operating mode and the source together.
// - The CPU is held for 66 oscillator cycles then 16 clock cycles.
// - Stop recovery resets the CPU, only the watchdog control is updated.
`include "rsr_consts.svh"
`default_nettype none
module rsr_ctrl
	import rsr_pkg::*;
#(
	parameter int GPIO_W     = `RSR_GPIO_W,
	parameter int OSC_CYCLES = `RSR_OSC_CYCLES,
	parameter int CLK_CYCLES = `RSR_CLK_CYCLES,
	parameter int OSC_DIV    = `RSR_OSC_DIV
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              rst_b,
	// System reset sources
	input  wire logic              power_on_evt,
	input  wire logic              brownout_detector,
	input  wire logic              reset_pin_b,
	input  wire logic              watchdog_timeout,
	input  wire logic              watchdog_reset_select,
	input  wire logic              debug_control_reset,
	// Stop mode recovery sources
	input  wire logic              stop_mode,
	input  wire logic [GPIO_W-1:0] gpio_in,
	input  wire logic [GPIO_W-1:0] gpio_wake_en,
	input  wire logic              debug_pin,
	// Reset outputs
	output logic                   cpu_reset_b,
	output logic                   ctrl_reset_b,
	output logic                   watchdog_ctl_update,
	output logic                   stop_recovery
);
	localparam int OW = `RSR_OSC_CNT_W;
	localparam int CW = `RSR_CLK_CNT_W;
	localparam logic [OW-1:0] OSC_LAST = OW'(OSC_CYCLES - 1);
	localparam logic [CW-1:0] CLK_LAST = CW'(CLK_CYCLES - 1);

	generate
		if (OSC_CYCLES < 1 || OSC_CYCLES > (1 << OW)) begin : g_bad_osc
			$error("rsr_ctrl: OSC_CYCLES out of range");
		end
		if (CLK_CYCLES < 1 || CLK_CYCLES > (1 << CW)) begin : g_bad_clk
			$error("rsr_ctrl: CLK_CYCLES out of range");
		end
	endgenerate

	rsr_state_t        state_q;
	rsr_state_t        state_d;
	logic [OW-1:0]     osc_cnt_q;
	logic [OW-1:0]     osc_cnt_d;
	logic [CW-1:0]     clk_cnt_q;
	logic [CW-1:0]     clk_cnt_d;
	logic              cpu_b_q;
	logic              cpu_b_d;
	logic              ctrl_b_q;
	logic              ctrl_b_d;
	logic              smr_q;
	logic              smr_d;
	logic              upd_q;
	logic              upd_d;
	logic [GPIO_W-1:0] gpio_prev_q;
	logic [GPIO_W-1:0] gpio_prev_d;
	logic [GPIO_W-1:0] gpio_edge;
	logic              osc_tick;
	logic              sys_other;
	logic              sys_src;
	logic              smr_src;
	logic              restart;

	rsr_tick_div #(
		.DIV (OSC_DIV)
	) u_osc (
		.clk   (clk),
		.rst_b (rst_b),
		.tick  (osc_tick)
	);

	// Wake edges only count on pins enabled as recovery sources
	genvar gi;
	generate
		for (gi = 0; gi < GPIO_W; gi++) begin : g_edge
			assign gpio_edge[gi] = gpio_wake_en[gi]
				& (gpio_in[gi] ^ gpio_prev_q[gi]);
		end
	endgenerate

	assign sys_other = power_on_evt | brownout_detector
		| ~reset_pin_b | debug_control_reset;
	// In stop the watchdog recovers instead of resetting
	assign sys_src = sys_other | (watchdog_timeout
		& watchdog_reset_select & ~stop_mode);
	assign smr_src = stop_mode & (watchdog_timeout | (|gpio_edge)
		| ~debug_pin);
	// Recovery is taken only from a running CPU; system reset always wins
	assign restart = sys_src | (smr_src & (state_q == RSR_RUN));

	always_comb begin
		state_d     = state_q;
		osc_cnt_d   = osc_cnt_q;
		clk_cnt_d   = clk_cnt_q;
		cpu_b_d     = cpu_b_q;
		ctrl_b_d    = ctrl_b_q;
		smr_d       = smr_q;
		upd_d       = 1'b0;
		gpio_prev_d = gpio_in;
		if (sys_src) begin
			// Held sources such as a low pin keep restarting the count
			state_d   = RSR_OSC_WAIT;
			osc_cnt_d = '0;
			clk_cnt_d = '0;
			cpu_b_d   = 1'b0;
			ctrl_b_d  = 1'b0;
			smr_d     = 1'b0;
		end else if (restart) begin
			state_d   = RSR_OSC_WAIT;
			osc_cnt_d = '0;
			clk_cnt_d = '0;
			cpu_b_d   = 1'b0;
			smr_d     = 1'b1;
			upd_d     = 1'b1;
		end else begin
			case (state_q)
				RSR_OSC_WAIT: begin
					if (osc_tick) begin
						if (osc_cnt_q == OSC_LAST) begin
							state_d   = RSR_CLK_WAIT;
							osc_cnt_d = '0;
						end else begin
							osc_cnt_d = osc_cnt_q + 1'b1;
						end
					end
				end
				RSR_CLK_WAIT: begin
					if (clk_cnt_q == CLK_LAST) begin
						state_d   = RSR_RUN;
						clk_cnt_d = '0;
						cpu_b_d   = 1'b1;
						ctrl_b_d  = 1'b1;
					end else begin
						clk_cnt_d = clk_cnt_q + 1'b1;
					end
				end
				RSR_RUN: begin
					state_d = RSR_RUN;
				end
				default: begin
					state_d = RSR_OSC_WAIT;
				end
			endcase
		end
	end

	// Block reset counts as power-on: full system reset latency
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q     <= RSR_OSC_WAIT;
			osc_cnt_q   <= '0;
			clk_cnt_q   <= '0;
			cpu_b_q     <= `RSR_CPU_RESET_B_RST;
			ctrl_b_q    <= `RSR_CTRL_RESET_B_RST;
			smr_q       <= 1'b0;
			upd_q       <= 1'b0;
			gpio_prev_q <= '0;
		end else begin
			state_q     <= state_d;
			osc_cnt_q   <= osc_cnt_d;
			clk_cnt_q   <= clk_cnt_d;
			cpu_b_q     <= cpu_b_d;
			ctrl_b_q    <= ctrl_b_d;
			smr_q       <= smr_d;
			upd_q       <= upd_d;
			gpio_prev_q <= gpio_prev_d;
		end
	end

	assign cpu_reset_b         = cpu_b_q;
	assign ctrl_reset_b        = ctrl_b_q;
	assign watchdog_ctl_update = upd_q;
	assign stop_recovery       = smr_q;

	// Cycles spent in the clock wait phase, for checking only
	logic [7:0] hlp_wait_q;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			hlp_wait_q <= '0;
		end else if (state_q == RSR_CLK_WAIT) begin
			hlp_wait_q <= hlp_wait_q + 8'h01;
		end else begin
			hlp_wait_q <= '0;
		end
	end

	// Oscillator ticks seen since the last restart, for checking only
	logic [7:0] hlp_ticks_q;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			hlp_ticks_q <= '0;
		end else if (restart) begin
			hlp_ticks_q <= '0;
		end else if (osc_tick && state_q == RSR_OSC_WAIT) begin
			hlp_ticks_q <= hlp_ticks_q + 8'h01;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	// Counter instead of a long repetition keeps the checker cheap
	sequence clk_phase_end_s;
		state_q == RSR_CLK_WAIT && hlp_wait_q == 8'(CLK_CYCLES - 1);
	endsequence

	sequence run_stop_wake_s;
		state_q == RSR_RUN && stop_mode && !sys_src;
	endsequence

	pin_reset_a: assert property (
		!reset_pin_b || brownout_detector |=> !cpu_b_q && !ctrl_b_q)
		else $error("pin or brownout did not reset");
	wdt_sel_a: assert property (
		watchdog_timeout && watchdog_reset_select && !stop_mode
		|=> !cpu_b_q && !ctrl_b_q && !smr_q)
		else $error("selected watchdog time-out did not reset");
	wdt_nosel_a: assert property (
		state_q == RSR_RUN && watchdog_timeout && !watchdog_reset_select
		&& !stop_mode && !sys_other |=> cpu_b_q && ctrl_b_q)
		else $error("unselected watchdog time-out reset the chip");
	debug_reset_a: assert property (
		debug_control_reset |=> !cpu_b_q && !ctrl_b_q && !smr_q)
		else $error("debug control bit did not reset");
	stop_wake_a: assert property (
		run_stop_wake_s ##0 (|gpio_edge || !debug_pin || watchdog_timeout)
		|=> !cpu_b_q && smr_q && upd_q)
		else $error("stop mode wake source ignored");
	reset_kind_a: assert property (
		state_q == RSR_RUN && stop_mode && watchdog_timeout
		&& watchdog_reset_select && !sys_other |=> smr_q && ctrl_b_q)
		else $error("watchdog in stop picked wrong reset type");
	osc_latency_a: assert property (
		$rose(state_q == RSR_CLK_WAIT) |-> hlp_ticks_q == 8'(OSC_CYCLES))
		else $error("oscillator latency not 66 cycles");
	clk_latency_a: assert property (
		clk_phase_end_s ##0 !sys_src |=> cpu_b_q && state_q == RSR_RUN)
		else $error("clock latency not 16 cycles");
	clk_early_a: assert property (
		state_q == RSR_CLK_WAIT && hlp_wait_q != 8'(CLK_CYCLES - 1)
		|=> !cpu_b_q)
		else $error("cpu released inside clock latency");
	early_release_a: assert property (
		state_q != RSR_RUN |-> !cpu_b_q)
		else $error("cpu released before latency ended");
	smr_regs_a: assert property (
		smr_q && !cpu_b_q |-> ctrl_b_q)
		else $error("stop recovery reset control registers");
	sys_regs_a: assert property (
		$rose(cpu_b_q) && !smr_q |-> $rose(ctrl_b_q))
		else $error("system reset released registers apart");
endmodule // rsr_ctrl
`default_nettype wire

// file: hw/rsr_consts.svh
// Constants of the reset and stop recovery controller
`ifndef RSR_CONSTS_SVH
`define RSR_CONSTS_SVH
`define RSR_OSC_CYCLES 66
`define RSR_CLK_CYCLES 16
`define RSR_OSC_DIV 4
`define RSR_GPIO_W 8
`define RSR_OSC_CNT_W 7
`define RSR_CLK_CNT_W 5
`define RSR_CPU_RESET_B_RST 1'h0
`define RSR_CTRL_RESET_B_RST 1'h0
`endif

// file: hw/rsr_pkg.sv
// Types of the reset and stop recovery controller
`default_nettype none
package rsr_pkg;
	typedef enum logic [1:0] {
		RSR_RUN,
		RSR_OSC_WAIT,
		RSR_CLK_WAIT
	} rsr_state_t;
endpackage
`default_nettype wire

// file: hw/rsr_tick_div.sv
// Divider that models the watchdog oscillator as a clock enable
`default_nettype none
module rsr_tick_div #(
	parameter int DIV = 4
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_b,
	// Enable pulse
	output logic      tick
);
	localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
	localparam logic [W-1:0] LAST = W'(DIV - 1);

	generate
		if (DIV < 2) begin : g_bad
			$error("rsr_tick_div: DIV must be at least 2");
		end
	endgenerate

	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;
	logic         tick_q;
	logic         tick_d;

	always_comb begin
		tick_d = 1'b0;
		cnt_d  = cnt_q + 1'b1;
		if (cnt_q == LAST) begin
			cnt_d  = '0;
			tick_d = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q  <= '0;
			tick_q <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			tick_q <= tick_d;
		end
	end

	assign tick = tick_q;
endmodule // rsr_tick_div
`default_nettype wire

// file: dv/rsr_pin_model.sv
// Pin-side model: reset pin, debug pin and GPIO levels
`default_nettype none
module rsr_pin_model (
	// Requests from the bench
	input  wire logic       pin_on,
	input  wire logic       dbg_on,
	input  wire logic [7:0] lvl,
	// Pins
	output logic            reset_pin_b,
	output logic            debug_pin,
	output logic [7:0]      gpio_in
);
	timeunit 1ns;
	timeprecision 1ns;
	// Both pins idle high, as if pulled up
	assign reset_pin_b = !pin_on;
	assign debug_pin   = !dbg_on;
	assign gpio_in     = lvl;
endmodule // rsr_pin_model
`default_nettype wire

// file: dv/test_reset_and_stop_recovery.sv
// Self-checking bench of the reset controller
`include "rsr_consts.svh"
`default_nettype none
module test_reset_and_stop_recovery;
	timeunit 1ns;
	timeprecision 1ns;
	// Slack covers the free-running oscillator phase
	localparam int LO = (`RSR_OSC_CYCLES - 1) * `RSR_OSC_DIV
		+ `RSR_CLK_CYCLES - 1;
	localparam int HI = `RSR_OSC_CYCLES * `RSR_OSC_DIV + `RSR_CLK_CYCLES + 3;
	logic       clk = 0, rst_b = 0, por = 0, bo = 0, pin_on = 0;
	logic       wdt = 0, sel = 0, dbg_bit = 0, stp = 0, dbg_on = 0;
	logic [7:0] lvl = 8'h00, wen = 8'h00;
	wire logic  pin_b, dpin, cpu_b, ctl_b, upd, srec;
	wire logic [7:0] gpio;
	int         error_cnt = 0, n_checks = 0;
	always #25 clk = ~clk;
	rsr_pin_model u_rsr_pin_model (
		.pin_on(pin_on), .dbg_on(dbg_on), .lvl(lvl),
		.reset_pin_b(pin_b), .debug_pin(dpin), .gpio_in(gpio)
	);
	rsr_ctrl u_rsr_ctrl (
		.clk(clk), .rst_b(rst_b), .power_on_evt(por),
		.brownout_detector(bo), .reset_pin_b(pin_b),
		.watchdog_timeout(wdt), .watchdog_reset_select(sel),
		.debug_control_reset(dbg_bit), .stop_mode(stp), .gpio_in(gpio),
		.gpio_wake_en(wen), .debug_pin(dpin), .cpu_reset_b(cpu_b),
		.ctrl_reset_b(ctl_b), .watchdog_ctl_update(upd),
		.stop_recovery(srec)
	);
	task automatic close_out;
		if (error_cnt == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [3:0] got, input logic [3:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_lat(input int n);
		n_checks++;
		if (n < LO || n > HI) begin
			error_cnt++;
			$display("mismatch t=%0t got=%h exp=%h", $time, n, LO);
		end
		if (n >= 400)
			close_out;
	endtask
	// Waits for the CPU release, bounded
	task automatic latency(input logic s);
		int n;
		n = 0;
		while (cpu_b !== 1'b1 && n < 400) begin
			@(negedge clk);
			n++;
			if (s)
				chk({2'h0, ctl_b, srec}, 4'h3);
		end
		chk_lat(n);
		chk({cpu_b, ctl_b, upd, srec}, {3'h6, s});
	endtask
	// Sources 0..4 are system ones, 5..7 recover from stop
	task automatic fire(input int k, input logic s);
		int n;
		stp = s;
		sel = 1'($urandom);
		case (k)
			0: por = 1;
			1: bo = 1;
			2: pin_on = 1;
			3: dbg_bit = 1;
			4: begin
				wdt = 1;
				sel = 1;
			end
			5: wdt = 1;
			6: lvl = lvl ^ wen;
			default: dbg_on = 1;
		endcase
		@(negedge clk);
		{por, bo, pin_on, dbg_bit, wdt, stp, dbg_on} = 7'h00;
		n = 0;
		while (cpu_b !== 1'b0 && n < 3) begin
			@(negedge clk);
			n++;
		end
		chk({cpu_b, ctl_b, upd, srec}, {1'b0, {3{k > 4}}});
		latency(k > 4);
	endtask
	// Events that must not reset
	task automatic quiet(input int k);
		stp = k[0];
		sel = 0;
		if (k[0])
			lvl = lvl ^ ~wen;
		else
			wdt = 1;
		repeat (12) begin
			@(negedge clk);
			wdt = 0;
			chk({cpu_b, ctl_b, upd, srec}, 4'hC);
		end
		stp = 0;
	endtask
	initial begin
		void'($urandom(23001));
		repeat (6) @(posedge clk);
		@(negedge clk);
		chk({cpu_b, ctl_b, upd, srec}, 4'h0);
		rst_b = 1;
		latency(0);
		for (int r = 0; r < 3; r++) begin
			wen = 8'h01 << ($urandom % 8);
			for (int k = 5; k < 8; k++)
				fire(k, 1);
			for (int k = 0; k < 5; k++)
				fire(k, k < 4 ? 1'($urandom) : 1'b0);
			quiet(0);
			quiet(1);
		end
		close_out;
	end
endmodule // test_reset_and_stop_recovery
`default_nettype wire
